// ===== pkg/lia_pkg.sv
// Constants and types shared by the legacy address and set transition logic
// =============================================================================
// How it works
// - Native unsegmented; legacy segmented by mode flags
// - Effective address base plus scaled index plus displacement
// - Start truncated; 16-bit end may pass 64K
// - Instruction pointer is code effective address
// - Segment base added, limit checked, 4G wrap
// - Legacy virtual address zero-extended to 64 bits
// - Legacy stores into fetched code are detected
// - Detection optional without translation; OS avoids aliases
// - Legacy to native exit makes instruction cache coherent
// - Legacy stores release, loads acquire, RMW both
// - Legacy stores wait for older native accesses
// - Native accesses wait for older legacy loads
// - Register stack engine inactive during legacy execution
// - Legacy exit invalidates stacked registers, clean count zero
// - Advanced load table ignored on legacy entry
// - Deferred token may abort any legacy instruction
// - Float consumes not-a-value: fault or propagate; vector ignores
package lia_pkg;

    // =========================================================================
    // Register port
    localparam int          REG_ADDR_W      = 8;
    localparam int          REG_DATA_W      = 32;
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_STATUS      = 8'h04;
    localparam logic [7:0]  REG_SMC_COUNT   = 8'h08;
    localparam logic [7:0]  REG_CLEAN       = 8'h0c;
    localparam logic [2:0]  CTRL_RESET      = 3'h5;
    localparam int          CTRL_RSE_EN     = 0;
    localparam int          CTRL_NAV_FAULT  = 1;
    localparam int          CTRL_SMC_EN     = 2;
    localparam int          STAT_LEGACY     = 0;
    localparam int          STAT_SMC_PEND   = 1;
    localparam int          STAT_ABORT      = 2;
    localparam int          STAT_SYNC       = 3;

    // =========================================================================
    // Address forming
    localparam int          VA_W            = 32;
    localparam int          NVA_W           = 64;
    localparam int          REAL_SHIFT      = 4;
    localparam int          LINE_BITS       = 6;
    localparam int          TAG_W           = VA_W - LINE_BITS;
    localparam int          TAG_ENTRIES     = 8;
    localparam int          TAG_PTR_W       = 3;
    localparam int          CLEAN_W         = 7;
    localparam logic [6:0]  CLEAN_RESET     = 7'h00;

    typedef enum logic [1:0] {ST_NATIVE, ST_LEGACY, ST_SYNC} lia_state_t;

endpackage

// ===== logic/lia_addr_gen.sv
// Legacy effective and virtual address forming, native pass-through
`timescale 1ns/100ps
module lia_addr_gen
    import lia_pkg::*;
(
    input  wire logic               legacy_i,
    input  wire logic               v86_i,
    input  wire logic               pe_i,
    input  wire logic               size32_i,
    input  wire logic [31:0]        base_i,
    input  wire logic [31:0]        index_i,
    input  wire logic [1:0]         scale_i,
    input  wire logic [31:0]        disp_i,
    input  wire logic [15:0]        selector_i,
    input  wire logic [31:0]        desc_base_i,
    input  wire logic [31:0]        limit_i,
    input  wire logic [3:0]         last_i,
    input  wire logic [63:0]        native_addr_i,
    output logic      [63:0]        start_o,
    output logic      [63:0]        end_o,
    output logic                    limit_fault_o
);
    // =========================================================================
    // Effective address
    wire logic [33:0] ea_sum    = {2'h0, base_i} + ({2'h0, index_i} << scale_i)
                                  + {2'h0, disp_i};
    wire logic [31:0] ea_start  = size32_i ? ea_sum[31:0] : {16'h0, ea_sum[15:0]};
    wire logic [32:0] ea_raw    = {1'h0, ea_start} + {29'h0, last_i};
    // A 16-bit end may carry into bit 16; a 32-bit end drops its carry
    wire logic [32:0] ea_end    = size32_i ? {1'h0, ea_raw[31:0]} : ea_raw;

    // =========================================================================
    // Segmentation: real and virtual-8086 take selector times 16
    wire logic        use_sel   = v86_i | ~pe_i;
    wire logic [31:0] seg_base  = use_sel ? {12'h0, selector_i, 4'h0} : desc_base_i;
    wire logic [32:0] va_s_sum  = {1'h0, seg_base} + {1'h0, ea_start};
    wire logic [32:0] va_e_sum  = {1'h0, seg_base} + ea_end;
    wire logic [63:0] nat_end   = native_addr_i + {60'h0, last_i};

    assign limit_fault_o = legacy_i & (ea_end > {1'h0, limit_i});
    assign start_o = legacy_i ? {32'h0, va_s_sum[31:0]} : native_addr_i;
    assign end_o   = legacy_i ? {32'h0, va_e_sum[31:0]} : nat_end;
endmodule // lia_addr_gen

// ===== logic/lia_tag_table.sv
// Small table of fetched legacy code line tags for store snooping
`timescale 1ns/100ps
module lia_tag_table
    import lia_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               clear_i,
    input  wire logic               wr_i,
    input  wire logic [TAG_W-1:0]   wr_tag_i,
    input  wire logic               cmp_i,
    input  wire logic [TAG_W-1:0]   cmp_tag_i,
    output logic                    hit_o
);
    logic [TAG_PTR_W-1:0] ptr;
    logic [TAG_ENTRIES-1:0] match;

    // =========================================================================
    // Entries, replaced round robin
    genvar g;
    generate
        for (g = 0; g < TAG_ENTRIES; g++) begin : g_ent
            logic             valid;
            logic [TAG_W-1:0] tag;
            wire logic        sel = wr_i & (ptr == TAG_PTR_W'(g));
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    valid <= 1'b0;
                    tag   <= '0;
                end else begin
                    valid <= ~clear_i & (valid | sel);
                    tag   <= sel ? wr_tag_i : tag;
                end
            end
            assign match[g] = valid & (tag == cmp_tag_i);
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr   <= '0;
            hit_o <= 1'b0;
        end else begin
            ptr   <= wr_i ? ptr + 1'b1 : ptr;
            hit_o <= cmp_i & (|match);
        end
    end
endmodule // lia_tag_table

// ===== logic/lia_legacy_xfer.sv
// Legacy memory reference forming and instruction set transition control
`timescale 1ns/100ps
module lia_legacy_xfer
    import lia_pkg::*;
(
    input  wire logic                       REF_CLK_I,
    input  wire logic                       SYS_RST_I,
    // Register port
    input  wire logic [lia_pkg::REG_ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [lia_pkg::REG_DATA_W-1:0] REG_WDATA_I,
    input  wire logic                       REG_WR_I,
    input  wire logic                       REG_RD_I,
    output logic      [lia_pkg::REG_DATA_W-1:0] REG_RDATA_O,
    // Legacy mode state
    input  wire logic                       VIRTUAL_8086_FLAG_I,
    input  wire logic                       PROTECTION_ENABLE_FLAG_I,
    input  wire logic                       CODE_SEGMENT_DEFAULT_SIZE_I,
    input  wire logic                       STACK_SEGMENT_BIG_FLAG_I,
    input  wire logic                       ADDR_SIZE_PREFIX_I,
    input  wire logic                       DATA_TRANSLATION_ENABLE_I,
    input  wire logic                       INSTRUCTION_TRANSLATION_ENABLE_I,
    input  wire logic [31:0]                LEGACY_INSTRUCTION_POINTER_I,
    // Set switching
    input  wire logic                       SET_SWITCH_I,
    input  wire logic                       LEGACY_BRANCH_I,
    output logic                            LEGACY_MODE_O,
    // Memory reference request
    input  wire logic                       REQ_VALID_I,
    output logic                            REQ_READY_O,
    input  wire logic                       REQ_CODE_I,
    input  wire logic                       REQ_STORE_I,
    input  wire logic                       REQ_RMW_I,
    input  wire logic                       REQ_STACK_I,
    input  wire logic [31:0]                REQ_BASE_I,
    input  wire logic [31:0]                REQ_INDEX_I,
    input  wire logic [1:0]                 REQ_SCALE_I,
    input  wire logic [31:0]                REQ_DISP_I,
    input  wire logic [15:0]                REQ_SELECTOR_I,
    input  wire logic [31:0]                REQ_SEG_BASE_I,
    input  wire logic [31:0]                REQ_SEG_LIMIT_I,
    input  wire logic [3:0]                 REQ_LAST_I,
    input  wire logic [63:0]                NATIVE_ADDR_I,
    input  wire logic                       NATIVE_ACQ_I,
    input  wire logic                       NATIVE_REL_I,
    input  wire logic                       NATIVE_PEND_I,
    input  wire logic                       LEGACY_LOAD_PEND_I,
    // Memory subsystem side
    output logic                            MEM_VALID_O,
    output logic      [63:0]                MEM_ADDR_O,
    output logic      [63:0]                MEM_END_ADDR_O,
    output logic                            MEM_STORE_O,
    output logic                            MEM_ACQ_O,
    output logic                            MEM_REL_O,
    output logic                            MEM_LIMIT_FAULT_O,
    output logic                            ICACHE_SYNC_O,
    input  wire logic                       ICACHE_SYNC_DONE_I,
    // Register stack and advanced load table
    output logic                            RSE_ACTIVE_O,
    output logic                            STACK_INVALIDATE_O,
    input  wire logic                       RSE_CLEAN_WR_I,
    input  wire logic [lia_pkg::CLEAN_W-1:0] RSE_CLEAN_I,
    output logic      [lia_pkg::CLEAN_W-1:0] RSE_CLEAN_COUNT_O,
    output logic                            ADVANCED_LOAD_TABLE_IGNORE_O,
    // Deferred tokens and not-a-value
    input  wire logic                       TOKEN_PRESENT_I,
    input  wire logic                       LEGACY_ISSUE_I,
    output logic                            CONSUME_ABORT_O,
    input  wire logic                       FP_OP_I,
    input  wire logic                       VEC_OP_I,
    input  wire logic                       FP_NOT_A_VALUE_I,
    output logic                            FP_INVALID_FAULT_O,
    output logic                            FP_NAV_PROPAGATE_O
);
    import lia_pkg::*;

    lia_state_t state;
    lia_state_t next_state;
    logic [2:0]  ctrl;
    logic        smc_pend;
    logic        abort_flag;
    logic        sync_to_native;
    logic [31:0] smc_count;
    logic [CLEAN_W-1:0] clean_count;
    logic        tag_hit;
    logic        store_chk;
    logic [63:0] gen_start;
    logic [63:0] gen_end;
    logic        gen_fault;

    // =========================================================================
    // Mode decode
    wire logic legacy   = (state == ST_LEGACY);
    wire logic in_sync  = (state == ST_SYNC);
    // Address width: code follows the code segment size, stack the stack flag,
    // the address size prefix flips the data choice
    wire logic data32   = CODE_SEGMENT_DEFAULT_SIZE_I ^ ADDR_SIZE_PREFIX_I;
    wire logic size32   = REQ_CODE_I  ? CODE_SEGMENT_DEFAULT_SIZE_I :
                          REQ_STACK_I ? STACK_SEGMENT_BIG_FLAG_I : data32;
    wire logic [31:0] g_base  = REQ_CODE_I ? LEGACY_INSTRUCTION_POINTER_I : REQ_BASE_I;
    wire logic [31:0] g_index = REQ_CODE_I ? 32'h0 : REQ_INDEX_I;
    wire logic [31:0] g_disp  = REQ_CODE_I ? 32'h0 : REQ_DISP_I;

    // =========================================================================
    // Ordering: a legacy store or locked access is a release and waits for
    // every older native access; native traffic waits for older legacy loads.
    // Legacy plain loads are let through, which the ordering model permits.
    wire logic is_wr    = REQ_STORE_I | REQ_RMW_I;
    wire logic leg_hold = legacy & is_wr & NATIVE_PEND_I;
    wire logic nat_hold = (state == ST_NATIVE) & LEGACY_LOAD_PEND_I;
    assign REQ_READY_O  = ~in_sync & ~leg_hold & ~nat_hold;
    wire logic accept   = REQ_VALID_I & REQ_READY_O;
    wire logic leg_acq  = ~REQ_CODE_I & (~REQ_STORE_I | REQ_RMW_I);
    wire logic leg_rel  = is_wr;

    lia_addr_gen u_addr_gen (
        .legacy_i       (legacy),
        .v86_i          (VIRTUAL_8086_FLAG_I),
        .pe_i           (PROTECTION_ENABLE_FLAG_I),
        .size32_i       (size32),
        .base_i         (g_base),
        .index_i        (g_index),
        .scale_i        (REQ_SCALE_I),
        .disp_i         (g_disp),
        .selector_i     (REQ_SELECTOR_I),
        .desc_base_i    (REQ_SEG_BASE_I),
        .limit_i        (REQ_SEG_LIMIT_I),
        .last_i         (REQ_LAST_I),
        .native_addr_i  (NATIVE_ADDR_I),
        .start_o        (gen_start),
        .end_o          (gen_end),
        .limit_fault_o  (gen_fault)
    );

    // =========================================================================
    // Self-modifying code snoop; detection is skipped without translation
    // since aliases then cannot be ruled out
    wire logic xlate_on = DATA_TRANSLATION_ENABLE_I & INSTRUCTION_TRANSLATION_ENABLE_I;
    wire logic snoop_on = ctrl[CTRL_SMC_EN] & xlate_on;
    wire logic fill_tag = accept & legacy & REQ_CODE_I;
    wire logic chk_tag  = accept & legacy & is_wr & snoop_on;
    wire logic tag_clr  = in_sync & ICACHE_SYNC_DONE_I;

    lia_tag_table u_tag_table (
        .clk_i      (REF_CLK_I),
        .rst_i      (SYS_RST_I),
        .clear_i    (tag_clr),
        .wr_i       (fill_tag),
        .wr_tag_i   (gen_start[VA_W-1:LINE_BITS]),
        .cmp_i      (chk_tag),
        .cmp_tag_i  (gen_start[VA_W-1:LINE_BITS]),
        .hit_o      (tag_hit)
    );

    // =========================================================================
    // Set state machine
    wire logic sync_on_branch = legacy & LEGACY_BRANCH_I & smc_pend & ~SET_SWITCH_I;
    wire logic sync_on_exit   = legacy & SET_SWITCH_I & smc_pend;
    wire logic leave_legacy   = legacy & SET_SWITCH_I;
    wire logic enter_legacy   = (state == ST_NATIVE) & SET_SWITCH_I;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_NATIVE: begin
                if (SET_SWITCH_I) begin
                    next_state = ST_LEGACY;
                end
            end
            ST_LEGACY: begin
                if (sync_on_exit || sync_on_branch) begin
                    next_state = ST_SYNC;
                end else if (SET_SWITCH_I) begin
                    next_state = ST_NATIVE;
                end
            end
            ST_SYNC: begin
                if (ICACHE_SYNC_DONE_I) begin
                    next_state = sync_to_native ? ST_NATIVE : ST_LEGACY;
                end
            end
            default: begin
                next_state = ST_NATIVE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state          <= ST_NATIVE;
            sync_to_native <= 1'b0;
        end else begin
            state          <= next_state;
            sync_to_native <= (sync_on_exit | sync_on_branch) ? sync_on_exit : sync_to_native;
        end
    end

    // =========================================================================
    // Pending detection; a hit in the cycle the sync starts is kept
    wire logic smc_clr = sync_on_exit | sync_on_branch;
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            smc_pend  <= 1'b0;
            smc_count <= 32'h0;
        end else begin
            smc_pend  <= tag_hit | (smc_pend & ~smc_clr);
            smc_count <= tag_hit ? smc_count + 32'h1 : smc_count;
        end
    end

    // =========================================================================
    // Memory request outputs
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            MEM_VALID_O       <= 1'b0;
            MEM_ADDR_O        <= 64'h0;
            MEM_END_ADDR_O    <= 64'h0;
            MEM_STORE_O       <= 1'b0;
            MEM_ACQ_O         <= 1'b0;
            MEM_REL_O         <= 1'b0;
            MEM_LIMIT_FAULT_O <= 1'b0;
        end else begin
            MEM_VALID_O       <= accept;
            MEM_ADDR_O        <= accept ? gen_start : MEM_ADDR_O;
            MEM_END_ADDR_O    <= accept ? gen_end : MEM_END_ADDR_O;
            MEM_STORE_O       <= accept & is_wr;
            MEM_ACQ_O         <= accept & (legacy ? leg_acq : NATIVE_ACQ_I);
            MEM_REL_O         <= accept & (legacy ? leg_rel : NATIVE_REL_I);
            MEM_LIMIT_FAULT_O <= accept & gen_fault;
        end
    end

    // =========================================================================
    // Register stack engine and advanced load table
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            STACK_INVALIDATE_O <= 1'b0;
            clean_count        <= CLEAN_RESET;
            ADVANCED_LOAD_TABLE_IGNORE_O      <= 1'b0;
        end else begin
            STACK_INVALIDATE_O <= leave_legacy;
            if (leave_legacy) begin
                clean_count <= CLEAN_RESET;
            end else if (RSE_CLEAN_WR_I && state == ST_NATIVE) begin
                clean_count <= RSE_CLEAN_I;
            end
            // Held from entry until the next legacy exit
            ADVANCED_LOAD_TABLE_IGNORE_O <= enter_legacy | (ADVANCED_LOAD_TABLE_IGNORE_O & ~leave_legacy);
        end
    end
    assign RSE_CLEAN_COUNT_O = clean_count;
    // Stays off through a sync that leads back into native code
    assign RSE_ACTIVE_O = ctrl[CTRL_RSE_EN] & (state == ST_NATIVE);

    // =========================================================================
    // Deferred tokens and not-a-value consumption
    wire logic abort_now = legacy & LEGACY_ISSUE_I & TOKEN_PRESENT_I;
    wire logic nav_use   = legacy & LEGACY_ISSUE_I & FP_OP_I & ~VEC_OP_I
                           & FP_NOT_A_VALUE_I;
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            CONSUME_ABORT_O    <= 1'b0;
            FP_INVALID_FAULT_O <= 1'b0;
            FP_NAV_PROPAGATE_O <= 1'b0;
        end else begin
            CONSUME_ABORT_O    <= abort_now;
            FP_INVALID_FAULT_O <= nav_use & ctrl[CTRL_NAV_FAULT];
            FP_NAV_PROPAGATE_O <= nav_use & ~ctrl[CTRL_NAV_FAULT];
        end
    end

    // =========================================================================
    // Register port
    wire logic wr_ctrl   = REG_WR_I & (REG_ADDR_I == REG_CTRL);
    wire logic wr_status = REG_WR_I & (REG_ADDR_I == REG_STATUS);
    wire logic abort_clr = wr_status & REG_WDATA_I[STAT_ABORT];
    wire logic [31:0] status_word = {28'h0, in_sync, abort_flag, smc_pend, legacy};
    wire logic [31:0] rd_mux =
        (REG_ADDR_I == REG_CTRL)      ? {29'h0, ctrl} :
        (REG_ADDR_I == REG_STATUS)    ? status_word :
        (REG_ADDR_I == REG_SMC_COUNT) ? smc_count :
        (REG_ADDR_I == REG_CLEAN)     ? {25'h0, clean_count} : 32'h0;

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ctrl        <= CTRL_RESET;
            abort_flag  <= 1'b0;
            REG_RDATA_O <= 32'h0;
        end else begin
            ctrl        <= wr_ctrl ? REG_WDATA_I[2:0] : ctrl;
            // Set wins over a write-one clear in the same cycle
            abort_flag  <= abort_now | (abort_flag & ~abort_clr);
            REG_RDATA_O <= REG_RD_I ? rd_mux : 32'h0;
        end
    end

    assign LEGACY_MODE_O = legacy;
    assign ICACHE_SYNC_O = in_sync;

endmodule // lia_legacy_xfer

// ===== dv/lia_assertions.sv
// Port-level checks on the legacy address and set transition block
`timescale 1ns/100ps
module lia_assertions (
    input logic       REF_CLK_I, SYS_RST_I, LEGACY_MODE_O, RSE_ACTIVE_O, ADVANCED_LOAD_TABLE_IGNORE_O,
    input logic       REQ_VALID_I, REQ_READY_O, REQ_STORE_I, REQ_CODE_I, NATIVE_PEND_I,
    input logic       LEGACY_LOAD_PEND_I, MEM_VALID_O, MEM_ACQ_O, MEM_REL_O, ICACHE_SYNC_O,
    input logic       SET_SWITCH_I, STACK_INVALIDATE_O,
    input logic [63:0] MEM_ADDR_O,
    input logic [6:0] RSE_CLEAN_COUNT_O
);
    // ========
    // Checks
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire take = REQ_VALID_I && REQ_READY_O && LEGACY_MODE_O;
    a_rse_off_legacy: assert property (LEGACY_MODE_O |-> !RSE_ACTIVE_O)
        else $error("stack engine active in legacy set");
    a_entry_legacy: assert property (!LEGACY_MODE_O && !ICACHE_SYNC_O && SET_SWITCH_I
        |=> LEGACY_MODE_O && ADVANCED_LOAD_TABLE_IGNORE_O) else $error("entry did not reach legacy");
    a_store_release: assert property (take && REQ_STORE_I |=> MEM_VALID_O && MEM_REL_O)
        else $error("legacy store without release");
    a_load_acquire: assert property (take && !REQ_STORE_I && !REQ_CODE_I |=> MEM_ACQ_O)
        else $error("legacy load without acquire");
    a_store_waits: assert property (LEGACY_MODE_O && REQ_STORE_I && NATIVE_PEND_I
        |-> !REQ_READY_O) else $error("legacy store passed native access");
    a_native_waits: assert property (!LEGACY_MODE_O && LEGACY_LOAD_PEND_I
        |-> !REQ_READY_O) else $error("native access passed legacy load");
    a_exit_clears: assert property (LEGACY_MODE_O && SET_SWITCH_I
        |=> STACK_INVALIDATE_O && RSE_CLEAN_COUNT_O == 7'h00) else $error("exit kept stack");
    a_zero_extend: assert property (MEM_VALID_O && $past(LEGACY_MODE_O)
        |-> MEM_ADDR_O[63:32] == 32'h0) else $error("legacy address not zero extended");
endmodule // lia_assertions

bind lia_legacy_xfer lia_assertions lia_assertions_inst (.*);

// ===== dv/lia_mem_model.sv
// Memory subsystem stand-in that completes instruction cache syncs
`timescale 1ns/100ps
module lia_mem_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic sync_i,
    output logic      done_o
);
    // ========
    // Sync handshake
    logic [1:0] cnt;
    // Slow answer, so the sync state is seen to stand for several cycles
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt    <= 2'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= sync_i && cnt == 2'h3;
            cnt    <= (sync_i && !done_o) ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule // lia_mem_model

// ===== dv/testbench.sv
// Self-checking bench for the legacy address and set transition block
`timescale 1ns/100ps
module testbench;
    import lia_pkg::*;
    // ========
    // Stimulus and observation
    logic REF_CLK_I = 0, SYS_RST_I = 1, REG_WR_I = 0, REG_RD_I = 0, SET_SWITCH_I = 0;
    logic VIRTUAL_8086_FLAG_I = 0, PROTECTION_ENABLE_FLAG_I = 1, CODE_SEGMENT_DEFAULT_SIZE_I = 1;
    logic STACK_SEGMENT_BIG_FLAG_I = 1, ADDR_SIZE_PREFIX_I = 0, LEGACY_BRANCH_I = 0;
    logic DATA_TRANSLATION_ENABLE_I = 1, INSTRUCTION_TRANSLATION_ENABLE_I = 1, REQ_VALID_I = 0;
    logic REQ_CODE_I = 0, REQ_STORE_I = 0, REQ_RMW_I = 0, REQ_STACK_I = 0, NATIVE_ACQ_I = 0;
    logic NATIVE_REL_I = 0, NATIVE_PEND_I = 0, LEGACY_LOAD_PEND_I = 0, RSE_CLEAN_WR_I = 0;
    logic TOKEN_PRESENT_I = 0, LEGACY_ISSUE_I = 0, FP_OP_I = 0, VEC_OP_I = 0, FP_NOT_A_VALUE_I = 0;
    logic [7:0]  REG_ADDR_I = 0;
    logic [31:0] REG_WDATA_I = 0, LEGACY_INSTRUCTION_POINTER_I = 0, REQ_BASE_I = 0, REQ_INDEX_I = 0;
    logic [31:0] REQ_DISP_I = 0, REQ_SEG_BASE_I = 0, REQ_SEG_LIMIT_I = '1, REG_RDATA_O;
    logic [63:0] NATIVE_ADDR_I = 64'h1234_5678_9abc_def0, MEM_ADDR_O, MEM_END_ADDR_O;
    logic [15:0] REQ_SELECTOR_I = 0;
    logic [1:0]  REQ_SCALE_I = 0;
    logic [3:0]  REQ_LAST_I = 0;
    logic [6:0]  RSE_CLEAN_I = 0, RSE_CLEAN_COUNT_O;
    logic LEGACY_MODE_O, REQ_READY_O, MEM_VALID_O, MEM_STORE_O, MEM_ACQ_O, MEM_REL_O, ICACHE_SYNC_O;
    logic MEM_LIMIT_FAULT_O, RSE_ACTIVE_O, STACK_INVALIDATE_O, ADVANCED_LOAD_TABLE_IGNORE_O, ICACHE_SYNC_DONE_I;
    logic CONSUME_ABORT_O, FP_INVALID_FAULT_O, FP_NAV_PROPAGATE_O;
    int   fails = 0, check_count = 0;
    lia_legacy_xfer lia_legacy_xfer_inst (.*);
    lia_mem_model lia_mem_model_inst (.clk_i(REF_CLK_I), .rst_i(SYS_RST_I),
        .sync_i(ICACHE_SYNC_O), .done_o(ICACHE_SYNC_DONE_I));
    `define CK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
        $display("wrong value at %0t: %h vs %h", $time, a, e); end end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK_I) {REG_ADDR_I, REG_WDATA_I, REG_WR_I} <= {a, d, 1'b1};
        @(posedge REF_CLK_I) REG_WR_I <= 0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge REF_CLK_I) {REG_ADDR_I, REG_RD_I} <= {a, 1'b1};
        @(posedge REF_CLK_I) REG_RD_I <= 0;
        #1 `CK(REG_RDATA_O, e)
    endtask
    task automatic go(input logic [63:0] s, input logic [63:0] e);
        @(posedge REF_CLK_I) REQ_VALID_I <= 1;
        @(posedge REF_CLK_I) REQ_VALID_I <= 0;
        #1 `CK({MEM_VALID_O, MEM_ADDR_O, MEM_END_ADDR_O}, {1'b1, s, e})
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        forever #25 REF_CLK_I = ~REF_CLK_I;
    end
    initial begin
        #20000 fails++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge REF_CLK_I);
        {SYS_RST_I, RSE_CLEAN_WR_I, RSE_CLEAN_I} <= {2'b01, 7'h2a};
        @(posedge REF_CLK_I) RSE_CLEAN_WR_I <= 0;
        rd(REG_CTRL, 32'h5);
        rd(REG_CLEAN, 32'h2a);
        wr(8'h40, 32'hff);
        rd(8'h40, 32'h0);
        @(posedge REF_CLK_I) LEGACY_LOAD_PEND_I <= 1;
        @(posedge REF_CLK_I) #1 `CK(REQ_READY_O, 1'b0)
        @(posedge REF_CLK_I) LEGACY_LOAD_PEND_I <= 0;
        go(NATIVE_ADDR_I, NATIVE_ADDR_I);
        $display("test native done");
        @(posedge REF_CLK_I) SET_SWITCH_I <= 1;
        @(posedge REF_CLK_I) {SET_SWITCH_I, REQ_CODE_I, LEGACY_INSTRUCTION_POINTER_I} <= 34'h1_0000_2000;
        #1 `CK({LEGACY_MODE_O, ADVANCED_LOAD_TABLE_IGNORE_O, RSE_ACTIVE_O}, 3'b110)
        go(64'h2000, 64'h2000);
        @(posedge REF_CLK_I) begin
            {REQ_CODE_I, REQ_STORE_I, ADDR_SIZE_PREFIX_I, REQ_LAST_I} <= {3'b011, 4'h3};
            {REQ_BASE_I, REQ_INDEX_I, REQ_SCALE_I, REQ_DISP_I} <= {32'hfff0, 32'h3, 2'h2, 32'h2};
            REQ_SEG_BASE_I <= 32'hffff2012;
        end
        go(64'h2010, 64'h2013);
        `CK({MEM_STORE_O, MEM_REL_O, MEM_ACQ_O, MEM_LIMIT_FAULT_O}, 4'hc)
        rd(REG_STATUS, 32'h3);
        @(posedge REF_CLK_I) LEGACY_BRANCH_I <= 1;
        @(posedge REF_CLK_I) LEGACY_BRANCH_I <= 0;
        #1 `CK({ICACHE_SYNC_O, LEGACY_MODE_O}, 2'b10)
        for (int i = 0; i < 9 && ICACHE_SYNC_O; i++) @(posedge REF_CLK_I);
        #1 `CK({ICACHE_SYNC_O, LEGACY_MODE_O, RSE_ACTIVE_O}, 3'b010)
        @(posedge REF_CLK_I) begin
            {VIRTUAL_8086_FLAG_I, REQ_STORE_I, REQ_CODE_I, REQ_SELECTOR_I} <= {3'b101, 16'h1234};
            {LEGACY_INSTRUCTION_POINTER_I, REQ_BASE_I, REQ_LAST_I} <= {32'h10, 32'h10, 4'h1};
        end
        go(64'h12350, 64'h12351);
        @(posedge REF_CLK_I) {REQ_CODE_I, REQ_RMW_I, REQ_INDEX_I, REQ_DISP_I} <= {2'b01, 64'h0};
        go(64'h12350, 64'h12351);
        `CK({MEM_ACQ_O, MEM_REL_O}, 2'b11)
        @(posedge REF_CLK_I) {REQ_STORE_I, NATIVE_PEND_I} <= 2'b11;
        @(posedge REF_CLK_I) #1 `CK(REQ_READY_O, 1'b0)
        @(posedge REF_CLK_I) NATIVE_PEND_I <= 0;
        wr(REG_CTRL, 32'h7);
        @(posedge REF_CLK_I) {TOKEN_PRESENT_I, LEGACY_ISSUE_I, FP_OP_I, FP_NOT_A_VALUE_I} <= 4'hf;
        @(posedge REF_CLK_I) LEGACY_ISSUE_I <= 0;
        #1 `CK({CONSUME_ABORT_O, FP_INVALID_FAULT_O, FP_NAV_PROPAGATE_O}, 3'b110)
        $display("test legacy done");
        @(posedge REF_CLK_I) SET_SWITCH_I <= 1;
        @(posedge REF_CLK_I) SET_SWITCH_I <= 0;
        #1 `CK(ICACHE_SYNC_O, 1'b1)
        for (int i = 0; i < 9 && ICACHE_SYNC_O; i++) @(posedge REF_CLK_I);
        #1 `CK({ICACHE_SYNC_O, LEGACY_MODE_O, RSE_ACTIVE_O}, 3'b001)
        rd(REG_CLEAN, 32'h0);
        rd(REG_SMC_COUNT, 32'h2);
        rd(REG_STATUS, 32'h4);
        wr(REG_STATUS, 32'h4);
        rd(REG_STATUS, 32'h0);
        $display("test exit done");
        tally_and_finish();
    end
endmodule // testbench
